// ===== core/aop_pkg.sv
// shared constants and types for the converter result port
package aop_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // least internal serial clock period per divider code, in ns
  localparam int SCLK_P0_NS = 25;
  localparam int SCLK_P1_NS = 50;
  localparam int SCLK_P2_NS = 100;
  localparam int SCLK_P3_NS = 200;
  // least times round up to whole cycles
  localparam logic [4:0] SCLK_P0_CYC = 5'((SCLK_P0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] SCLK_P1_CYC = 5'((SCLK_P1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] SCLK_P2_CYC = 5'((SCLK_P2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] SCLK_P3_CYC = 5'((SCLK_P3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // pin positions on the shared data bus
  localparam int PIN_DIV_LO  = 2;
  localparam int PIN_CLK_SRC = 4;
  localparam int PIN_FPOL    = 5;
  localparam int PIN_INV     = 6;
  localparam int PIN_RDMODE  = 7;
  localparam int PIN_SDO     = 8;
  localparam int PIN_SCLK    = 9;
  localparam int PIN_SYNC    = 10;
  // positions of the static pins in the synchroniser word
  localparam int SY_SER  = 16;
  localparam int SY_SWAP = 17;
  localparam int SY_OCF  = 18;
  localparam logic [3:0]  BIT_LAST   = 4'hf;
  localparam logic [1:0]  FIFO_DEPTH = 2'h2;
  localparam logic [15:0] OE_ALL     = 16'hffff;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } aop_st_type;

  typedef struct packed {
    logic       ser;
    logic       swap;
    logic       ocf;
    logic       cs;
    logic       fpol;
    logic       inv;
    logic       rdc;
    logic [1:0] div;
  } aop_cfg_type;

  typedef struct packed {
    logic [18:0]      sync1;
    logic [18:0]      sync2;
    logic             sclk_d;
    logic [1:0][15:0] mem;
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
    logic             in_rdy;
    logic [15:0]      par_word;
    aop_st_type       st;
    logic [15:0]      shreg;
    logic [3:0]       bitcnt;
    logic [4:0]       divcnt;
    logic             sclk_int;
    logic [15:0]      d_out;
    logic [15:0]      d_oe;
  } aop_state_type;

  localparam aop_state_type RST_STATE = '0;
endpackage

// ===== core/aop_port.sv
// result port of the converter: parallel bus or serial port on shared pins
`timescale 1ns/1ps
module aop_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // static selection pins
  input  wire logic        port_type_select,
  input  wire logic        byte_order_select,
  input  wire logic        output_code_format,
  // results from the conversion engine
  input  wire logic [15:0] result,
  input  wire logic        result_valid,
  output logic             result_ready,
  input  wire logic        conv_busy,
  // shared data bus pins
  input  wire logic [15:0] d_in,
  output logic [15:0]      d_out,
  output logic [15:0]      d_oe
);
  aop_pkg::aop_state_type q;
  aop_pkg::aop_state_type next;
  aop_pkg::aop_cfg_type   cfg;
  logic [15:0]            head;
  logic [15:0]            fmt_head;
  logic [7:0]             head_lo;
  logic [7:0]             head_hi;
  logic [4:0]             per;
  logic [4:0]             low_len;
  logic                   master;
  logic                   push;
  logic                   pop;
  logic                   pop_par;
  logic                   start;
  logic                   shift_ev;
  logic                   slave_ev;
  logic                   sclk_s;

  always_comb begin
    cfg.ser  = q.sync2[aop_pkg::SY_SER];
    cfg.swap = q.sync2[aop_pkg::SY_SWAP];
    cfg.ocf  = q.sync2[aop_pkg::SY_OCF];
    cfg.cs   = q.sync2[aop_pkg::PIN_CLK_SRC];
    cfg.fpol = q.sync2[aop_pkg::PIN_FPOL];
    cfg.inv  = q.sync2[aop_pkg::PIN_INV];
    cfg.rdc  = q.sync2[aop_pkg::PIN_RDMODE];
    cfg.div  = (!cfg.cs && !cfg.rdc) ? q.sync2[aop_pkg::PIN_DIV_LO +: 2] : 2'h0;
  end

  assign master   = cfg.ser && !cfg.cs;
  assign head     = q.mem[q.rp];
  assign fmt_head = {head[15] ^ ~cfg.ocf, head[14:0]};
  assign head_lo  = fmt_head[7:0];
  assign head_hi  = fmt_head[15:8];
  assign sclk_s   = q.sync2[aop_pkg::PIN_SCLK];

  always_comb begin
    unique case (cfg.div)
      2'h0: per = aop_pkg::SCLK_P0_CYC;
      2'h1: per = aop_pkg::SCLK_P1_CYC;
      2'h2: per = aop_pkg::SCLK_P2_CYC;
      2'h3: per = aop_pkg::SCLK_P3_CYC;
    endcase
  end
  assign low_len = per - (per >> 1);

  // update edge of the host clock, swapped when inverted
  assign slave_ev = ((sclk_s ^ cfg.inv) && !(q.sclk_d ^ cfg.inv));
  assign shift_ev = (q.st == aop_pkg::ST_SHIFT) &&
                    (master ? (q.divcnt == per - 5'h1) : slave_ev);

  // as master, read mode decides when a frame may begin; as slave any buffered word starts one
  always_comb begin
    if (!cfg.ser || q.cnt == 2'h0 || q.st != aop_pkg::ST_IDLE) begin
      start = 1'b0;
    end else if (master) begin
      start = cfg.rdc ? conv_busy : !conv_busy;
    end else begin
      start = 1'b1;
    end
  end

  assign push    = result_valid && q.in_rdy;
  assign pop_par = !cfg.ser && (q.cnt != 2'h0);
  assign pop     = pop_par || start;

  always_comb begin
    next = q;
    // pins cross in through two flops before use
    next.sync1  = {output_code_format, byte_order_select, port_type_select, d_in};
    next.sync2  = q.sync1;
    next.sclk_d = sclk_s;

    // two-entry buffer: a stalled reader holds words, writer sees ready drop
    if (push) begin
      next.mem[q.wp] = result;
      next.wp        = ~q.wp;
    end
    if (pop) begin
      next.rp = ~q.rp;
    end
    next.cnt    = q.cnt + {1'b0, push} - {1'b0, pop};
    next.in_rdy = (next.cnt != aop_pkg::FIFO_DEPTH);

    if (pop_par) begin
      next.par_word = cfg.swap ? {head_lo, head_hi} : fmt_head;
    end

    unique case (q.st)
      aop_pkg::ST_IDLE: begin
        next.divcnt = 5'h0;
        if (start) begin
          next.shreg  = fmt_head;
          next.bitcnt = aop_pkg::BIT_LAST;
          next.st     = aop_pkg::ST_SHIFT;
        end
      end
      aop_pkg::ST_SHIFT: begin
        // internal clock: low phase then high phase per bit
        next.divcnt = (q.divcnt == per - 5'h1) ? 5'h0 : q.divcnt + 5'h1;
        // shift on the chosen clock edge
        if (shift_ev) begin
          if (q.bitcnt == 4'h0) begin
            next.st = aop_pkg::ST_DONE;
          end else begin
            next.shreg  = {q.shreg[14:0], 1'b0};
            next.bitcnt = q.bitcnt - 4'h1;
          end
        end
      end
      aop_pkg::ST_DONE: begin
        // one idle cycle keeps frames apart
        next.divcnt = 5'h0;
        next.st     = aop_pkg::ST_IDLE;
      end
    endcase
    next.sclk_int = master && (next.st == aop_pkg::ST_SHIFT) && (next.divcnt >= low_len);

    if (!cfg.ser) begin
      // parallel: every pin is a result bit
      next.d_out = q.par_word;
      next.d_oe  = aop_pkg::OE_ALL;
    end else begin
      // serial: bits 0-1 float, 2-7 become inputs
      next.d_out = 16'h0000;
      next.d_oe  = 16'h0000;
      next.d_out[aop_pkg::PIN_SDO]  = q.shreg[15];
      next.d_oe[aop_pkg::PIN_SDO]   = 1'b1;
      next.d_out[aop_pkg::PIN_SCLK] = q.sclk_int ^ cfg.inv;
      // clock pin driven only as master
      next.d_oe[aop_pkg::PIN_SCLK]  = master;
      next.d_out[aop_pkg::PIN_SYNC] = (q.st == aop_pkg::ST_SHIFT) ^ cfg.fpol;
      next.d_oe[aop_pkg::PIN_SYNC]  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= aop_pkg::RST_STATE;
    end else begin
      q <= next;
    end
  end

  assign result_ready = q.in_rdy;
  assign d_out        = q.d_out;
  assign d_oe         = q.d_oe;

  a_swap_lanes: assert property (@(posedge clk) disable iff (!resetn)
    (pop_par && cfg.swap) |=> (q.par_word == {$past(head_lo), $past(head_hi)}))
    else $error("byte lanes not swapped");

  a_swap_straight: assert property (@(posedge clk) disable iff (!resetn)
    (pop_par && !cfg.swap) |=> (q.par_word == $past(fmt_head)))
    else $error("byte lanes moved without swap");

  a_code_msb: assert property (@(posedge clk) disable iff (!resetn)
    (pop_par && !cfg.swap) |=> (q.par_word[15] == ($past(head[15]) ^ !$past(cfg.ocf))))
    else $error("msb coding wrong");

  a_serial_low_hiz: assert property (@(posedge clk) disable iff (!resetn)
    cfg.ser |=> (d_oe[1:0] == 2'b00 && d_oe[7:2] == 6'h00))
    else $error("low bits driven in serial mode");

  // release edge still shows reset outputs, so wait for a sampled high reset
  a_parallel_all_out: assert property (@(posedge clk) disable iff (!resetn)
    (resetn && !cfg.ser) |=> (d_oe == aop_pkg::OE_ALL && d_out == $past(q.par_word)))
    else $error("parallel bus not fully driven");

  a_div_ignored: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.ser && (cfg.cs || cfg.rdc)) |-> (per == aop_pkg::SCLK_P0_CYC))
    else $error("divider used outside read-after-convert");

  a_master_clk_oe: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.ser && !cfg.cs) |=> d_oe[aop_pkg::PIN_SCLK])
    else $error("master clock not driven");

  a_slave_clk_hiz: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.ser && cfg.cs) |=> !d_oe[aop_pkg::PIN_SCLK])
    else $error("slave drives clock pin");

  a_sync_idle_lvl: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.ser && q.st == aop_pkg::ST_IDLE) |=> (d_out[aop_pkg::PIN_SYNC] == $past(cfg.fpol)))
    else $error("idle frame sync level wrong");

  a_msb_first: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == aop_pkg::ST_IDLE && start) |=> (q.shreg == $past(fmt_head)) ##1
      (d_out[aop_pkg::PIN_SDO] == $past(q.shreg[15])))
    else $error("first bit is not the msb");

  a_read_during: assert property (@(posedge clk) disable iff (!resetn)
    (start && master) |-> (conv_busy == cfg.rdc))
    else $error("frame started in wrong read mode");

  a_bit_period: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == aop_pkg::ST_SHIFT && master) |-> (q.divcnt < per))
    else $error("internal clock period exceeded");

  a_low_byte_keep: assert property (@(posedge clk) disable iff (!resetn)
    (pop_par && !cfg.swap) |=> (q.par_word[7:0] == $past(head[7:0])))
    else $error("low byte lane moved");

  a_code_swapped: assert property (@(posedge clk) disable iff (!resetn)
    (pop_par && cfg.swap) |=> (q.par_word[7] == ($past(head[15]) ^ !$past(cfg.ocf))))
    else $error("msb coding wrong in swapped lane");

  a_par_no_frame: assert property (@(posedge clk) disable iff (!resetn)
    !cfg.ser |-> !start)
    else $error("serial frame started in parallel mode");

  a_ser_no_par: assert property (@(posedge clk) disable iff (!resetn)
    cfg.ser |-> !pop_par)
    else $error("parallel pop in serial mode");

  a_div_follows: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.ser && !cfg.cs && !cfg.rdc) |-> (cfg.div == q.sync2[aop_pkg::PIN_DIV_LO +: 2]))
    else $error("divider pins not used in read-after-convert");

  a_master_low_first: assert property (@(posedge clk) disable iff (!resetn)
    (start && master) |=> !q.sclk_int)
    else $error("internal clock not low at frame start");

  a_slave_no_clk: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.ser && cfg.cs) |=> !q.sclk_int)
    else $error("internal clock runs as slave");

  a_slave_shift_edge: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == aop_pkg::ST_SHIFT && cfg.ser && cfg.cs) |-> (shift_ev == slave_ev))
    else $error("slave shift off the host clock edge");

  a_sync_active_lvl: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.ser && q.st == aop_pkg::ST_SHIFT) |=> (d_out[aop_pkg::PIN_SYNC] == !$past(cfg.fpol)))
    else $error("active frame sync level wrong");

  a_sync_driven: assert property (@(posedge clk) disable iff (!resetn)
    cfg.ser |=> d_oe[aop_pkg::PIN_SYNC])
    else $error("frame sync not driven");

  a_clk_sense: assert property (@(posedge clk) disable iff (!resetn)
    (cfg.ser && !cfg.cs) |=> (d_out[aop_pkg::PIN_SCLK] == ($past(q.sclk_int) ^ $past(cfg.inv))))
    else $error("clock sense wrong");

  a_sdo_driven: assert property (@(posedge clk) disable iff (!resetn)
    cfg.ser |=> (d_oe[aop_pkg::PIN_SDO] && d_out[aop_pkg::PIN_SDO] == $past(q.shreg[15])))
    else $error("serial data pin not fed by shift register");

  a_shift_left: assert property (@(posedge clk) disable iff (!resetn)
    (shift_ev && q.bitcnt != 4'h0) |=> (q.shreg == {$past(q.shreg[14:0]), 1'b0}))
    else $error("shift register not moving toward msb");

  a_frame_end: assert property (@(posedge clk) disable iff (!resetn)
    (shift_ev && q.bitcnt == 4'h0) |=> (q.st == aop_pkg::ST_DONE))
    else $error("frame not closed after last bit");

  a_frame_load: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == aop_pkg::ST_IDLE && start) |=> (q.bitcnt == aop_pkg::BIT_LAST && q.st == aop_pkg::ST_SHIFT))
    else $error("frame not loaded with full bit count");

  a_clk_phase: assert property (@(posedge clk) disable iff (!resetn)
    (master && q.st == aop_pkg::ST_SHIFT) |-> (q.sclk_int == (q.divcnt >= low_len)))
    else $error("internal clock phase wrong");

endmodule // aop_port

// ===== bench/aop_host.sv
// host side model: drives serial pins, clocks slave frames, collects words
`timescale 1ns/1ps
module aop_host (
  // clock and host configuration
  input  wire logic                 clk,
  input  wire aop_pkg::aop_cfg_type cfg,
  // device pins
  input  wire logic [15:0]          d_out,
  input  wire logic [15:0]          d_oe,
  output logic [15:0]               pins,
  // collected frames
  output logic [15:0]               frame_word,
  output logic [4:0]                frame_bits,
  output logic [7:0]                frame_cnt,
  output logic [7:0]                sclk_per
);
  logic [15:0] drv;
  logic [15:0] sh;
  logic [4:0]  bits = '0;
  logic        sclk_h = 1'b1;
  logic        sclk_q = 1'b0;
  logic        sync_q = 1'b0;
  logic [3:0]  hcnt = '0;
  logic [7:0]  pcnt = '0;
  logic        sync_on;
  logic        cap;
  // undriven lines are pulled up
  // host pin drive
  always_comb begin
    drv = 16'hffff;
    if (cfg.ser) begin
      drv[7:2] = {cfg.rdc, cfg.inv, cfg.fpol, cfg.cs, cfg.div};
      if (cfg.cs) drv[9] = sclk_h;
    end
    pins = (d_oe & d_out) | (~d_oe & drv);
    sync_on = cfg.ser & d_oe[10] & (d_out[10] ^ cfg.fpol);
    cap = (cfg.cs ^ cfg.inv) ? (~pins[9] & sclk_q) : (pins[9] & ~sclk_q);
  end
  initial frame_cnt = '0;
  always @(posedge clk) begin
    sclk_q <= pins[9];
    sync_q <= sync_on;
    // clock stands still outside frames; first edge is a capture edge
    if (!(cfg.cs && sync_on)) begin
      sclk_h <= ~cfg.inv;
      hcnt <= '0;
    end else if (hcnt == 4'h9) begin
      sclk_h <= ~sclk_h;
      hcnt <= '0;
    end else hcnt <= hcnt + 4'h1;
    if (pins[9] && !sclk_q) begin
      sclk_per <= pcnt;
      pcnt <= 8'h01;
    end else pcnt <= pcnt + 8'h01;
    if (cap && sync_on) begin
      sh <= {sh[14:0], pins[8]};
      bits <= bits + 5'h01;
    end
    if (sync_q && !sync_on) begin
      frame_word <= sh;
      frame_bits <= bits;
      frame_cnt <= frame_cnt + 8'h01;
      bits <= '0;
    end
  end
endmodule // aop_host

// ===== bench/testbench.sv
// self-checking bench of the converter result port
`timescale 1ns/1ps
module testbench;
  logic                 clk = 1'b0;
  logic                 resetn = 1'b0;
  aop_pkg::aop_cfg_type cfg = '0;
  logic [15:0]          result = '0;
  logic                 result_valid = 1'b0;
  logic                 conv_busy = 1'b0;
  logic                 result_ready;
  logic [15:0]          d_in, d_out, d_oe, frame_word;
  logic [4:0]           frame_bits;
  logic [7:0]           frame_cnt, sclk_per;
  int                   fail_count = 0;
  int                   checks_done = 0;
  int                   cycles = 0;
  aop_pkg::aop_cfg_type tbl[7] = '{9'h1c0, 9'h119, 9'h1ca, 9'h113, 9'h147, 9'h162, 9'h13d};
  aop_port dut (.clk(clk), .resetn(resetn), .port_type_select(cfg.ser),
    .byte_order_select(cfg.swap), .output_code_format(cfg.ocf), .result(result),
    .result_valid(result_valid), .result_ready(result_ready), .conv_busy(conv_busy),
    .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
  aop_host host (.clk(clk), .cfg(cfg), .d_out(d_out), .d_oe(d_oe), .pins(d_in),
    .frame_word(frame_word), .frame_bits(frame_bits), .frame_cnt(frame_cnt),
    .sclk_per(sclk_per));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    @(posedge clk);
    result <= w;
    result_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (result_ready !== 1'b1 && n < 2000);
    if (result_ready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH at %0t: word never taken", $time);
    end
    @(posedge clk);
    result_valid <= 1'b0;
  endtask
  task automatic par_test();
    logic [15:0] w, v;
    for (int k = 0; k < 4; k++) begin
      w = 16'ha5c3 ^ 16'(k * 'h1111);
      @(posedge clk);
      cfg <= 9'(k * 'h40);
      repeat (6) @(posedge clk);
      send(w);
      repeat (5) @(negedge clk);
      // bit 0 of k sets output_code_format, bit 1 byte_order_select
      v = k[0] ? w : w ^ 16'h8000;
      v = k[1] ? {v[7:0], v[15:8]} : v;
      check(d_out, v, "parallel word");
      check(d_oe, aop_pkg::OE_ALL, "parallel enables");
    end
    $display("parallel test done");
  endtask
  task automatic ser_test(input aop_pkg::aop_cfg_type c);
    int base, n, per_ns;
    int ns[4] = '{25, 50, 100, 200};
    logic [15:0] w;
    w = 16'h9c35 ^ {c, 7'h00};
    @(posedge clk);
    cfg <= c;
    conv_busy <= ~c.rdc;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check(16'(d_oe[1:0]), 16'h0000, "low pins released");
    check(16'(d_oe[9]), 16'(!c.cs), "clock drive");
    check(16'(d_out[10]), 16'(c.fpol), "idle sync level");
    base = frame_cnt;
    send(w);
    send(~w);
    repeat (20) @(negedge clk);
    check(16'(frame_cnt), 16'(base), "early frame");
    if (!c.cs) check(16'(result_ready), 16'h0000, "full buffer");
    @(posedge clk);
    conv_busy <= c.rdc;
    for (int i = 1; i < 3; i++) begin
      n = 0;
      while (frame_cnt != 8'(base + i) && n < 3000) begin
        @(negedge clk);
        n++;
      end
      check(frame_word, (c.ocf ? w : w ^ 16'h8000), "serial word");
      if (n >= 3000) begin
        fail_count++;
        $display("MISMATCH at %0t: frame %0d never ended", $time, i);
      end
      check(16'(frame_bits), 16'h0010, "frame bits");
      per_ns = ns[c.rdc ? 0 : c.div];
      if (!c.cs) check(16'(sclk_per), 16'((per_ns + 9) / 10), "sclk period");
      w = ~w;
    end
    $display("serial test %h done", c);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    par_test();
    foreach (tbl[i]) ser_test(tbl[i]);
    end_of_test();
  end
endmodule // testbench
